// ==== hdl/dic_pkg.sv ====
// Constants, register map and field layout of the digital I/O conditioning block.
// Assumes a single 50 MHz clock; all times are converted to cycles here.
package dic_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int NCH = 8;
  localparam int NCNT = 2 * NCH;
  localparam int TMR_W = 24;
  localparam int CNT_W = 32;
  localparam int LIM_W = 16;
  localparam int HOUR_W = 38;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 50_000_000;
  localparam int CYC_PER_US = CLK_HZ / 1_000_000;
  localparam int FLT0_US = 100;
  localparam int FLT1_US = 1000;
  localparam int FLT2_US = 10000;
  localparam int FLT3_US = 20000;
  localparam int EXT0_US = 1000;
  localparam int EXT1_US = 15000;
  localparam int EXT2_US = 100000;
  localparam int EXT3_US = 200000;
  localparam int INRUSH_US = 100000;
  localparam int HOUR_S = 3600;
  localparam int FLT0_CYC = FLT0_US * CYC_PER_US;
  localparam int FLT1_CYC = FLT1_US * CYC_PER_US;
  localparam int FLT2_CYC = FLT2_US * CYC_PER_US;
  localparam int FLT3_CYC = FLT3_US * CYC_PER_US;
  localparam int EXT0_CYC = EXT0_US * CYC_PER_US;
  localparam int EXT1_CYC = EXT1_US * CYC_PER_US;
  localparam int EXT2_CYC = EXT2_US * CYC_PER_US;
  localparam int EXT3_CYC = EXT3_US * CYC_PER_US;
  localparam int INRUSH_CYC = INRUSH_US * CYC_PER_US;
  localparam longint HOUR_CYC = longint'(HOUR_S) * longint'(CLK_HZ);

  // ----------------------------------------------------------------
  // Counter limits
  // ----------------------------------------------------------------
  localparam logic [LIM_W-1:0] LIM_MIN = 16'h0001;
  localparam logic [LIM_W-1:0] LIM_MAX = 16'hfde8;
  localparam logic [CNT_W-1:0] CNT_SCALE = 32'h000003e8;
  localparam logic [CNT_W-1:0] CNT_SAT = 32'hffffffff;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_CH_EN = 8'h04;
  localparam logic [7:0] REG_FLT_MODE = 8'h08;
  localparam logic [7:0] REG_IDLE_MODE = 8'h0c;
  localparam logic [7:0] REG_CNT_CLR = 8'h10;
  localparam logic [7:0] REG_STATUS = 8'h14;
  localparam logic [7:0] REG_MASK = 8'h18;
  localparam logic [7:0] REG_ERR_A = 8'h1c;
  localparam logic [7:0] REG_ERR_B = 8'h20;
  localparam logic [7:0] REG_LEVEL = 8'h24;
  localparam logic [1:0] SEL_LIMIT = 2'h1;
  localparam logic [1:0] SEL_COUNT = 2'h2;

  // ----------------------------------------------------------------
  // Control fields and reset values
  // ----------------------------------------------------------------
  localparam int CTRL_W = 9;
  localparam int CTL_PRIO_SW = 0;
  localparam int CTL_INSUP_EN = 1;
  localparam int CTL_INRUSH_EN = 2;
  localparam int CTL_FLT_LSB = 3;
  localparam int CTL_EXT_LSB = 5;
  localparam int CTL_OSHORT_EN = 7;
  localparam int CTL_MANUAL = 8;
  localparam logic [CTRL_W-1:0] CTRL_RST = 9'h0aa;
  localparam int CHEN_IN_OPEN = 0;
  localparam int CHEN_OUT_OPEN = 8;
  localparam int CHEN_CNT = 16;

  // ----------------------------------------------------------------
  // Status bits and output modes
  // ----------------------------------------------------------------
  localparam int ST_W = 7;
  localparam int ST_SAVE = 6;
  localparam logic [1:0] MODE_CLEAR = 2'h0;
  localparam logic [1:0] MODE_HOLD = 2'h1;
  localparam logic [1:0] MODE_DRIVE_ON_FORCED = 2'h2;

endpackage : dic_pkg

// ==== hdl/dic_onoff_cnt.sv ====
// One saturating ON/OFF operation counter with threshold compare.
// Assumes the channel level is already conditioned and synchronous to clk.
`timescale 1ns/1ns
module dic_onoff_cnt
  import dic_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Control
  input wire logic chanLevel,
  input wire logic enable,
  input wire logic clear,
  input wire logic load,
  input wire logic [CNT_W-1:0] loadVal,
  input wire logic [LIM_W-1:0] limit,
  // Result
  output logic [CNT_W-1:0] count,
  output logic over
);

  logic [CNT_W-1:0] cnt_ff, nxt_cnt;
  logic prevLvl_ff, nxt_prevLvl;
  logic over_ff, nxt_over;
  logic [CNT_W-1:0] thresh;

  assign thresh = CNT_W'(limit) * CNT_SCALE;

  always_comb begin
    nxt_prevLvl = chanLevel;
    nxt_cnt = cnt_ff;
    if (clear) begin
      nxt_cnt = '0;
    end else if (load) begin
      nxt_cnt = loadVal;
    end else if (enable && prevLvl_ff && !chanLevel && cnt_ff != CNT_SAT) begin
      // Counted at on-to-off so a full cycle is one operation
      nxt_cnt = cnt_ff + 32'h00000001;
    end
    nxt_over = enable && (cnt_ff > thresh);
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_ff <= '0;
      prevLvl_ff <= 1'b0;
      over_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      prevLvl_ff <= nxt_prevLvl;
      over_ff <= nxt_over;
    end
  end

  assign count = cnt_ff;
  assign over = over_ff;

endmodule : dic_onoff_cnt

// ==== hdl/dic_io_cond.sv ====
// Discrete input/output channel conditioning and supervision with APB registers.
// Assumes field and bus-unit inputs are synchronous to clk; reset is power-on.
//
// Overview of operation
// - Input changes shorter than the selected filter time (0.1/1/10/20 ms, default 1 ms) are ignored.
// - A detected input is held for the selected extension time (1/15/100/200 ms, default 15 ms).
// - With the inrush filter enabled, overcurrent is ignored for 100 ms after power-up; default off.
// - Input supply short raises an error when enabled, which is the default.
// - Input open circuit raises an error per enabled channel, only on hardware that can sense it.
// - The input ON/OFF counter flags an error when its count exceeds the set value times 1000.
// - Counts are offered for saving every hour and can be reloaded after power returns.
// - Output load short raises an error when enabled, which is the default.
// - Auto restart clears a short error with the fault; manual keeps it until reset or until the manual or short enable bit is cleared.
// - Output open circuit raises an error per enabled channel.
// - On communication error each output goes off, holds, or is forced on per channel.
// - During communication idle each output goes off, holds, or is forced on per channel.
// - Per-channel fault and idle modes act only when priority selects software.
// - The output ON/OFF counter flags an error above set value times 1000 and clears on command.
// - With switch priority, one switch setting decides off or hold for all outputs.
//
// Design decisions made here: the register offsets and the APB interface to the registers.
`timescale 1ns/1ns
module dic_io_cond
  import dic_pkg::*;
#(
  parameter logic [TMR_W-1:0] FLT_CYC0 = TMR_W'(FLT0_CYC),
  parameter logic [TMR_W-1:0] FLT_CYC1 = TMR_W'(FLT1_CYC),
  parameter logic [TMR_W-1:0] FLT_CYC2 = TMR_W'(FLT2_CYC),
  parameter logic [TMR_W-1:0] FLT_CYC3 = TMR_W'(FLT3_CYC),
  parameter logic [TMR_W-1:0] EXT_CYC0 = TMR_W'(EXT0_CYC),
  parameter logic [TMR_W-1:0] EXT_CYC1 = TMR_W'(EXT1_CYC),
  parameter logic [TMR_W-1:0] EXT_CYC2 = TMR_W'(EXT2_CYC),
  parameter logic [TMR_W-1:0] EXT_CYC3 = TMR_W'(EXT3_CYC),
  parameter logic [TMR_W-1:0] INRUSH_CYCLES = TMR_W'(INRUSH_CYC),
  parameter logic [HOUR_W-1:0] HOUR_CYCLES = HOUR_W'(HOUR_CYC),
  parameter logic IN_OPEN_HW = 1'b1
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // APB slave
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Field inputs and sensing
  input wire logic [NCH-1:0] inRaw,
  input wire logic inSupplyShortDet,
  input wire logic [NCH-1:0] inOpenDet,
  input wire logic [NCH-1:0] outShortDet,
  input wire logic [NCH-1:0] outOpenDet,
  // Fieldbus unit
  input wire logic [NCH-1:0] busOutData,
  input wire logic commFault,
  input wire logic commIdle,
  input wire logic switchHoldSel,
  // Results
  output logic [NCH-1:0] inLevel,
  output logic [NCH-1:0] outDrive,
  output logic irq
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [CTRL_W-1:0] ctrl_ff, nxt_ctrl;
  logic [31:0] chEn_ff, nxt_chEn;
  logic [2*NCH-1:0] fltMode_ff, nxt_fltMode;
  logic [2*NCH-1:0] idleMode_ff, nxt_idleMode;
  logic [ST_W-1:0] status_ff, nxt_status;
  logic [ST_W-1:0] mask_ff, nxt_mask;
  logic [LIM_W-1:0] lim_ff [NCNT];
  logic [LIM_W-1:0] nxt_lim [NCNT];
  logic ready_ff, nxt_ready;
  logic [31:0] rdata_ff, nxt_rdata;
  logic slvErr_ff, nxt_slvErr;
  logic irq_ff, nxt_irq;
  logic accessCyc, wrEn, hit;
  logic [31:0] rdMux;
  logic [1:0] addrSel;
  logic [3:0] addrIdx;
  logic [TMR_W-1:0] fltLim, extLim;
  logic [NCH-1:0] extLvl;
  logic [CNT_W-1:0] cntVal [NCNT];
  logic [NCNT-1:0] cntOver, cntLoad;
  logic [NCNT-1:0] cntLevel;
  logic [NCH-1:0] drive_ff, nxt_drive;
  logic inSupErr_ff, nxt_inSupErr;
  logic [NCH-1:0] inOpenErr_ff, nxt_inOpenErr;
  logic [NCH-1:0] outShortErr_ff, nxt_outShortErr;
  logic [NCH-1:0] outOpenErr_ff, nxt_outOpenErr;
  logic [ST_W-2:0] errNow, errPrev_ff;
  logic [TMR_W-1:0] inrush_ff, nxt_inrush;
  logic inrushDone_ff, nxt_inrushDone;
  logic [HOUR_W-1:0] hour_ff, nxt_hour;
  logic hourTick;
  logic shortMasked;

  // ----------------------------------------------------------------
  // APB slave: one wait state, writes land on the pready edge
  // ----------------------------------------------------------------
  assign accessCyc = psel && penable && !ready_ff;
  assign wrEn = psel && penable && ready_ff && pwrite;
  assign addrSel = paddr[7:6];
  assign addrIdx = paddr[5:2];

  always_comb begin
    hit = 1'b1;
    rdMux = '0;
    if (addrSel == SEL_LIMIT) begin
      rdMux = 32'(lim_ff[addrIdx]);
    end else if (addrSel == SEL_COUNT) begin
      rdMux = cntVal[addrIdx];
    end else begin
      case (paddr)
        REG_CTRL: rdMux = 32'(ctrl_ff);
        REG_CH_EN: rdMux = chEn_ff;
        REG_FLT_MODE: rdMux = 32'(fltMode_ff);
        REG_IDLE_MODE: rdMux = 32'(idleMode_ff);
        REG_CNT_CLR: rdMux = '0;
        REG_STATUS: rdMux = 32'(status_ff);
        REG_MASK: rdMux = 32'(mask_ff);
        REG_ERR_A: rdMux = {outOpenErr_ff, outShortErr_ff, cntOver[NCH-1:0], inOpenErr_ff};
        REG_ERR_B: rdMux = {23'h000000, inSupErr_ff, cntOver[NCNT-1:NCH]};
        REG_LEVEL: rdMux = {16'h0000, drive_ff, extLvl};
        default: hit = 1'b0;
      endcase
    end
    nxt_ready = accessCyc;
    nxt_rdata = accessCyc ? rdMux : rdata_ff;
    nxt_slvErr = accessCyc && !hit;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ready_ff <= 1'b0;
      rdata_ff <= '0;
      slvErr_ff <= 1'b0;
    end else begin
      ready_ff <= nxt_ready;
      rdata_ff <= nxt_rdata;
      slvErr_ff <= nxt_slvErr;
    end
  end

  // ----------------------------------------------------------------
  // Configuration registers and interrupt status
  // ----------------------------------------------------------------
  always_comb begin
    nxt_ctrl = ctrl_ff;
    nxt_chEn = chEn_ff;
    nxt_fltMode = fltMode_ff;
    nxt_idleMode = idleMode_ff;
    nxt_mask = mask_ff;
    nxt_lim = lim_ff;
    cntLoad = '0;
    nxt_status = status_ff;
    if (wrEn) begin
      case (paddr)
        REG_CTRL: nxt_ctrl = pwdata[CTRL_W-1:0];
        REG_CH_EN: nxt_chEn = pwdata;
        REG_FLT_MODE: nxt_fltMode = pwdata[2*NCH-1:0];
        REG_IDLE_MODE: nxt_idleMode = pwdata[2*NCH-1:0];
        REG_STATUS: nxt_status = status_ff & ~pwdata[ST_W-1:0];
        REG_MASK: nxt_mask = pwdata[ST_W-1:0];
        default: nxt_ctrl = ctrl_ff;
      endcase
      if (addrSel == SEL_LIMIT) begin
        // Set value is kept inside its legal range
        if (pwdata[LIM_W-1:0] < LIM_MIN) begin
          nxt_lim[addrIdx] = LIM_MIN;
        end else if (pwdata[LIM_W-1:0] > LIM_MAX) begin
          nxt_lim[addrIdx] = LIM_MAX;
        end else begin
          nxt_lim[addrIdx] = pwdata[LIM_W-1:0];
        end
      end
      if (addrSel == SEL_COUNT) begin
        cntLoad[addrIdx] = 1'b1;
      end
    end
    // A new event wins over a same-cycle clear
    nxt_status = nxt_status | {hourTick, errNow & ~errPrev_ff};
    nxt_irq = |(nxt_status & mask_ff);
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_ff <= CTRL_RST;
      chEn_ff <= '0;
      fltMode_ff <= '0;
      idleMode_ff <= '0;
      status_ff <= '0;
      mask_ff <= '0;
      irq_ff <= 1'b0;
      for (int i = 0; i < NCNT; i++) begin
        lim_ff[i] <= LIM_MIN;
      end
    end else begin
      ctrl_ff <= nxt_ctrl;
      chEn_ff <= nxt_chEn;
      fltMode_ff <= nxt_fltMode;
      idleMode_ff <= nxt_idleMode;
      status_ff <= nxt_status;
      mask_ff <= nxt_mask;
      irq_ff <= nxt_irq;
      lim_ff <= nxt_lim;
    end
  end

  // ----------------------------------------------------------------
  // Input filter followed by pulse extension
  // ----------------------------------------------------------------
  always_comb begin
    case (ctrl_ff[CTL_FLT_LSB +: 2])
      2'h0: fltLim = FLT_CYC0;
      2'h1: fltLim = FLT_CYC1;
      2'h2: fltLim = FLT_CYC2;
      default: fltLim = FLT_CYC3;
    endcase
    case (ctrl_ff[CTL_EXT_LSB +: 2])
      2'h0: extLim = EXT_CYC0;
      2'h1: extLim = EXT_CYC1;
      2'h2: extLim = EXT_CYC2;
      default: extLim = EXT_CYC3;
    endcase
  end

  for (genvar g = 0; g < NCH; g++) begin : g_in
    logic [TMR_W-1:0] fCnt_ff, nxt_fCnt, eCnt_ff, nxt_eCnt;
    logic fLvl_ff, nxt_fLvl, eLvl_ff, nxt_eLvl;
    always_comb begin
      nxt_fCnt = '0;
      nxt_fLvl = fLvl_ff;
      if (inRaw[g] != fLvl_ff) begin
        // A change must persist the whole filter time
        if (fCnt_ff >= fltLim - 24'h000001) begin
          nxt_fLvl = inRaw[g];
        end else begin
          nxt_fCnt = fCnt_ff + 24'h000001;
        end
      end
      nxt_eLvl = eLvl_ff;
      nxt_eCnt = eCnt_ff;
      // Extension sees only the filtered level
      if (fLvl_ff && !eLvl_ff) begin
        nxt_eLvl = 1'b1;
        nxt_eCnt = '0;
      end else if (eLvl_ff) begin
        if (eCnt_ff < extLim - 24'h000001) begin
          nxt_eCnt = eCnt_ff + 24'h000001;
        end else if (!fLvl_ff) begin
          nxt_eLvl = 1'b0;
        end
      end
    end
    always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
        fCnt_ff <= '0;
        fLvl_ff <= 1'b0;
        eCnt_ff <= '0;
        eLvl_ff <= 1'b0;
      end else begin
        fCnt_ff <= nxt_fCnt;
        fLvl_ff <= nxt_fLvl;
        eCnt_ff <= nxt_eCnt;
        eLvl_ff <= nxt_eLvl;
      end
    end
    assign extLvl[g] = eLvl_ff;
  end

  // ----------------------------------------------------------------
  // Output level on fault and idle
  // ----------------------------------------------------------------
  always_comb begin
    logic [1:0] md;
    md = MODE_CLEAR;
    nxt_drive = busOutData;
    for (int c = 0; c < NCH; c++) begin
      md = commFault ? fltMode_ff[2*c +: 2] : idleMode_ff[2*c +: 2];
      if (commFault || commIdle) begin
        if (!ctrl_ff[CTL_PRIO_SW]) begin
          nxt_drive[c] = switchHoldSel && drive_ff[c];
        end else begin
          case (md)
            MODE_HOLD: nxt_drive[c] = drive_ff[c];
            MODE_DRIVE_ON_FORCED: nxt_drive[c] = 1'b1;
            default: nxt_drive[c] = 1'b0;
          endcase
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Fault supervision, inrush window and hourly save tick
  // ----------------------------------------------------------------
  // Manual restart latches a short error until reset or a control write that clears the manual or short enable bit
  assign shortMasked = ctrl_ff[CTL_INRUSH_EN] && !inrushDone_ff;
  assign hourTick = (hour_ff == HOUR_CYCLES - 38'h0000000001);

  always_comb begin
    nxt_inrush = inrushDone_ff ? inrush_ff : inrush_ff + 24'h000001;
    nxt_inrushDone = inrushDone_ff || (inrush_ff >= INRUSH_CYCLES - 24'h000001);
    nxt_hour = hourTick ? '0 : hour_ff + 38'h0000000001;
    nxt_inSupErr = ctrl_ff[CTL_INSUP_EN] && inSupplyShortDet;
    nxt_inOpenErr = IN_OPEN_HW ? (chEn_ff[CHEN_IN_OPEN +: NCH] & inOpenDet) : '0;
    nxt_outOpenErr = chEn_ff[CHEN_OUT_OPEN +: NCH] & outOpenDet;
    nxt_outShortErr = shortMasked ? '0 : outShortDet;
    if (ctrl_ff[CTL_MANUAL]) begin
      nxt_outShortErr = nxt_outShortErr | outShortErr_ff;
    end
    if (!ctrl_ff[CTL_OSHORT_EN]) begin
      nxt_outShortErr = '0;
    end
    errNow = {|cntOver[NCNT-1:NCH], |outOpenErr_ff, |outShortErr_ff,
              |cntOver[NCH-1:0], |inOpenErr_ff, inSupErr_ff};
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      drive_ff <= '0;
      inrush_ff <= '0;
      inrushDone_ff <= 1'b0;
      hour_ff <= '0;
      inSupErr_ff <= 1'b0;
      inOpenErr_ff <= '0;
      outOpenErr_ff <= '0;
      outShortErr_ff <= '0;
      errPrev_ff <= '0;
    end else begin
      drive_ff <= nxt_drive;
      inrush_ff <= nxt_inrush;
      inrushDone_ff <= nxt_inrushDone;
      hour_ff <= nxt_hour;
      inSupErr_ff <= nxt_inSupErr;
      inOpenErr_ff <= nxt_inOpenErr;
      outOpenErr_ff <= nxt_outOpenErr;
      outShortErr_ff <= nxt_outShortErr;
      errPrev_ff <= errNow;
    end
  end

  // ----------------------------------------------------------------
  // ON/OFF counters: inputs 0..7, outputs 8..15
  // ----------------------------------------------------------------
  assign cntLevel = {drive_ff, extLvl};

  for (genvar k = 0; k < NCNT; k++) begin : g_cnt
    dic_onoff_cnt u_cnt (
      .clk(clk),
      .reset_n(reset_n),
      .chanLevel(cntLevel[k]),
      .enable(chEn_ff[CHEN_CNT + k]),
      .clear(wrEn && paddr == REG_CNT_CLR && pwdata[k]),
      .load(cntLoad[k]),
      .loadVal(pwdata),
      .limit(lim_ff[k]),
      .count(cntVal[k]),
      .over(cntOver[k])
    );
  end

  assign prdata = rdata_ff;
  assign pready = ready_ff;
  assign pslverr = slvErr_ff;
  assign inLevel = extLvl;
  assign outDrive = drive_ff;
  assign irq = irq_ff;

endmodule : dic_io_cond

// ==== tb/dic_field_model.sv ====
// Actuator load model: short and open sense lines seen by the block.
// Assumes outDrive comes straight from the block under test.
`timescale 1ns/1ns
module dic_field_model
  import dic_pkg::*;
(
  // Drive and fault setup
  input wire logic [NCH-1:0] outDrive,
  input wire logic [NCH-1:0] shortMask,
  input wire logic [NCH-1:0] openMask,
  // Sense lines
  output logic [NCH-1:0] outShortDet,
  output logic [NCH-1:0] outOpenDet
);
  // A shorted load only shows overcurrent while it is driven
  assign outShortDet = outDrive & shortMask;
  assign outOpenDet = openMask;
endmodule : dic_field_model

// ==== tb/dic_io_cond_props.sv ====
// Bus and channel properties of the I/O conditioning block.
// Assumes every filter select is at least 4 and every extension select at least 8 cycles.
`timescale 1ns/1ns
module dic_io_cond_chk
  import dic_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Channels
  input wire logic [NCH-1:0] inRaw,
  input wire logic [NCH-1:0] busOutData,
  input wire logic commFault,
  input wire logic commIdle,
  input wire logic [NCH-1:0] inLevel,
  input wire logic [NCH-1:0] outDrive
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  sequence accessWait;
    psel && penable && !pready;
  endsequence
  sequence answerPulse;
    pready ##1 !pready;
  endsequence
  access_answer_a: assert property (accessWait |=> answerPulse)
    else $error("access not answered after one wait state");
  slverr_ready_a: assert property (pslverr |-> pready)
    else $error("slave error without ready");
  refused_data_a: assert property (pslverr |-> prdata == 32'h0)
    else $error("refused access returned data");
  idle_ready_a: assert property (!psel |=> !pready)
    else $error("ready without a request");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  out_follow_a: assert property ($past(reset_n) && !commFault && !commIdle |=>
    outDrive == $past(busOutData)) else $error("output does not follow bus data");
  // Shortest filter is 4 cycles, so a rise needs raw high two and three cycles back
  filter_rise_a: assert property ((inLevel & ~$past(inLevel)
    & ~($past(inRaw, 2) & $past(inRaw, 3))) == '0) else $error("input rose without filter");
  extend_hold_a: assert property ((~inLevel & $past(inLevel) & ~$past(inLevel, 8)) == '0)
    else $error("input fell before extension time");
endmodule : dic_io_cond_chk

bind dic_io_cond dic_io_cond_chk chk_u (.clk(clk), .reset_n(reset_n), .psel(psel),
  .penable(penable), .prdata(prdata), .pready(pready), .pslverr(pslverr), .inRaw(inRaw),
  .busOutData(busOutData), .commFault(commFault), .commIdle(commIdle), .inLevel(inLevel),
  .outDrive(outDrive));

// ==== tb/tb.sv ====
// Self-checking bench for the I/O conditioning block with an actuator load model.
// Assumes short timers at the default selects: filter 8, extension 20, inrush 50, hour 200.
`timescale 1ns/1ns
module tb;
  import dic_pkg::*;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, inSupplyShortDet = 1'b0;
  logic commFault = 1'b0, commIdle = 1'b0, switchHoldSel = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, q;
  logic pready, pslverr, sErr, irq;
  logic [NCH-1:0] inRaw = '0, inOpenDet = '0, busOutData = '0, shortMask = '0, openMask = '0;
  logic [NCH-1:0] outShortDet, outOpenDet, inLevel, outDrive;
  int err_count = 0;
  int total_checks = 0;
  // Reset values: address beside expected word
  logic [39:0] rows [14] = '{40'h00000000aa, 40'h0400000000, 40'h0800000000, 40'h0c00000000,
    40'h1000000000, 40'h1400000000, 40'h1800000000, 40'h1c00000000, 40'h2000000000,
    40'h2400000000, 40'h4000000001, 40'h7c00000001, 40'h8000000000, 40'hbc00000000};

  always #10 clk = ~clk;

  // Only the selects the bench uses are shortened; the others keep their real times
  dic_io_cond #(.FLT_CYC1(24'h8), .EXT_CYC1(24'h14), .INRUSH_CYCLES(24'h32),
    .HOUR_CYCLES(38'hc8)) dut_u (.clk(clk), .reset_n(reset_n),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .inRaw(inRaw),
    .inSupplyShortDet(inSupplyShortDet), .inOpenDet(inOpenDet), .outShortDet(outShortDet),
    .outOpenDet(outOpenDet), .busOutData(busOutData), .commFault(commFault),
    .commIdle(commIdle), .switchHoldSel(switchHoldSel), .inLevel(inLevel),
    .outDrive(outDrive), .irq(irq));
  dic_field_model model_u (.outDrive(outDrive), .shortMask(shortMask), .openMask(openMask),
    .outShortDet(outShortDet), .outOpenDet(outOpenDet));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task end_sim;
    if (err_count == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : end_sim
  task chk(input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      err_count++;
      $display("Error at %0t: seen %h expected %h", $time, s, e);
    end
  endtask : chk
  task cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc
  // Master holds the whole request until the edge that samples pready
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      err_count++;
      end_sim();
    end
    q = prdata;
    sErr = pslverr;
    {psel, penable} <= 2'b00;
  endtask : apb
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task rc(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(q, e);
  endtask : rc
  task tog;
    busOutData <= 8'h01;
    cyc(3);
    busOutData <= 8'h00;
    cyc(3);
  endtask : tog

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    cyc(3);
    reset_n <= 1'b1;
    foreach (rows[i]) rc(rows[i][39:32], rows[i][31:0]);
    rc(8'h30, 32'h0);
    chk({31'h0, sErr}, 32'h1);
    inRaw <= 8'h01;
    cyc(5);
    inRaw <= 8'h00;
    cyc(12);
    chk(32'(inLevel), 32'h0);
    inRaw <= 8'h01;
    cyc(12);
    inRaw <= 8'h00;
    cyc(15);
    chk(32'(inLevel), 32'h1);
    cyc(30);
    chk(32'(inLevel), 32'h0);
    wr(REG_CH_EN, 32'h101);
    {inSupplyShortDet, inOpenDet, openMask} <= {1'b1, 8'h01, 8'h01};
    rc(REG_ERR_A, 32'h01000001);
    rc(REG_ERR_B, 32'h100);
    wr(REG_CTRL, 32'h0a8);
    rc(REG_ERR_B, 32'h0);
    wr(REG_CTRL, 32'h0aa);
    {inSupplyShortDet, inOpenDet, openMask, busOutData, shortMask} <= {17'h0, 8'hff, 8'h01};
    rc(REG_ERR_A, 32'h10000);
    shortMask <= 8'h00;
    rc(REG_ERR_A, 32'h0);
    wr(REG_MASK, 32'h8);
    cyc(2);
    chk(32'(irq), 32'h1);
    wr(REG_STATUS, 32'h8);
    cyc(2);
    chk(32'(irq), 32'h0);
    wr(REG_CTRL, 32'h02a);
    shortMask <= 8'h01;
    rc(REG_ERR_A, 32'h0);
    wr(REG_CTRL, 32'h1aa);
    cyc(3);
    shortMask <= 8'h00;
    rc(REG_ERR_A, 32'h10000);
    wr(REG_FLT_MODE, 32'he4e4);
    wr(REG_IDLE_MODE, 32'haaaa);
    wr(REG_CTRL, 32'h1ab);
    {commFault, busOutData} <= {1'b1, 8'h00};
    cyc(3);
    chk(32'(outDrive), 32'h66);
    {commFault, commIdle} <= 2'b01;
    cyc(3);
    chk(32'(outDrive), 32'hff);
    wr(REG_CTRL, 32'h1aa);
    cyc(3);
    chk(32'(outDrive), 32'h0);
    {switchHoldSel, commIdle, busOutData} <= {2'b10, 8'h5a};
    cyc(3);
    {commFault, busOutData} <= {1'b1, 8'h00};
    cyc(3);
    chk(32'(outDrive), 32'h5a);
    commFault <= 1'b0;
    wr(REG_CH_EN, 32'h01010000);
    wr(8'h80, 32'h3e8);
    wr(8'ha0, 32'h3e8);
    inRaw <= 8'h01;
    cyc(12);
    inRaw <= 8'h00;
    cyc(45);
    tog();
    rc(8'h80, 32'h3e9);
    rc(8'ha0, 32'h3e9);
    rc(REG_ERR_A, 32'h10100);
    rc(REG_ERR_B, 32'h1);
    wr(REG_CNT_CLR, 32'h101);
    rc(8'ha0, 32'h0);
    rc(REG_ERR_B, 32'h0);
    wr(8'h40, 32'h0);
    rc(8'h40, 32'h1);
    wr(8'h40, 32'hffff);
    rc(8'h40, 32'hfde8);
    wr(8'ha0, 32'hffffffff);
    tog();
    rc(8'ha0, 32'hffffffff);
    busOutData <= 8'hff;
    reset_n <= 1'b0;
    cyc(3);
    chk(32'(outDrive), 32'h0);
    reset_n <= 1'b1;
    wr(REG_CTRL, 32'h0ae);
    shortMask <= 8'h01;
    rc(REG_ERR_A, 32'h0);
    cyc(60);
    rc(REG_ERR_A, 32'h10000);
    // Hour tick lands 200 cycles after release, beside the late short event
    cyc(130);
    rc(REG_STATUS, 32'h48);
    end_sim();
  end
endmodule : tb
